// *** rtl/tpr_consts.svh ***
// Constants for the timer pin routing block
`ifndef TPR_CONSTS_SVH
`define TPR_CONSTS_SVH
`define TPR_MODE_NONE      4'h0
`define TPR_MODE_B_TRIG    4'h1
`define TPR_MODE_A_GATE    4'h2
`define TPR_MODE_GATE_TRIG 4'h3
`define TPR_MODE_B_CLK     4'h4
`define TPR_MODE_A_TRIG    4'h5
`define TPR_MODE_GATE_CLK  4'h6
`define TPR_MODE_DUAL_TRIG 4'h7
`define TPR_MODE_UP_DOWN   4'h8
`define TPR_MODE_DIR_CLK   4'h9
`define TPR_MODE_TRIG_DIR  4'ha
`define TPR_MODE_DIR_ONLY  4'hb
`define TPR_MODE_AUTODISC  4'hc
`define TPR_MODE_TRIG_CLK  4'hd
`define TPR_MODE_CLK_TRIG  4'he
`define TPR_MODE_TRIG_GATE 4'hf
`define TPR_EDGE_RISE      1'b0
`define TPR_EDGE_FALL      1'b1
`define TPR_ACT_NOP        2'h0
`define TPR_ACT_SET        2'h1
`define TPR_ACT_RESET      2'h2
`define TPR_ACT_TOGGLE     2'h3
`define TPR_SYNC_RST       3'h0
`endif

// *** rtl/tpr_pkg.sv ***
// Types for the timer pin routing block
package tpr_pkg;
	typedef logic [1:0] tpr_action_t;
	typedef logic [3:0] tpr_mode_t;
endpackage

// *** rtl/tpr_timer_pin_routing.sv ***
// Input steering and output action logic of the multifunction timer
`timescale 1ns/1ps
`include "tpr_consts.svh"
module tpr_timer_pin_routing
	import tpr_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        ext_input_a_in,
	input  wire logic        ext_input_b_in,
	input  wire tpr_mode_t   input_mode_field_in,
	input  wire logic [1:0]  edge_sel_a_in,
	input  wire logic [1:0]  edge_sel_b_in,
	input  wire logic        sw_direction_bit_in,
	input  wire logic        bivalue_mode_in,
	input  wire logic        prescaler_tick_in,
	input  wire logic        compare_first_event_in,
	input  wire logic        compare_second_event_in,
	input  wire logic        wrap_event_in,
	input  wire tpr_action_t out_a_cmp0_act_in,
	input  wire tpr_action_t out_a_cmp1_act_in,
	input  wire tpr_action_t out_a_wrap_act_in,
	input  wire tpr_action_t out_b_cmp0_act_in,
	input  wire tpr_action_t out_b_cmp1_act_in,
	input  wire tpr_action_t out_b_wrap_act_in,
	input  wire logic        preset_a_level_in,
	input  wire logic        preset_b_level_in,
	input  wire logic        preset_a_load_in,
	input  wire logic        preset_b_load_in,
	input  wire logic        overflow_event_route_in,
	input  wire logic        compare0_event_route_in,
	output logic             prescaler_clk_out,
	output logic             count_up_out,
	output logic             count_step_up_out,
	output logic             count_step_down_out,
	output logic             trigger_first_out,
	output logic             trigger_second_out,
	output logic             direction_up_out,
	output logic             timer_output_a_out,
	output logic             timer_output_b_out,
	output logic             on_chip_event_out
);

	// Synchronisers for the pins
	logic [2:0] sync_a_r;
	logic [2:0] sync_b_r;
	logic       lvl_a_r;
	logic       lvl_b_r;
	logic       dir_lvl_r;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync_a_r <= `TPR_SYNC_RST;
			sync_b_r <= `TPR_SYNC_RST;
		end else begin
			sync_a_r <= {sync_a_r[1:0], ext_input_a_in};
			sync_b_r <= {sync_b_r[1:0], ext_input_b_in};
		end
	end

	// Agreed level moves when stages two and three match
	wire a_agree = (sync_a_r[1] == sync_a_r[2]);
	wire b_agree = (sync_b_r[1] == sync_b_r[2]);
	wire a_lvl_nxt = a_agree ? sync_a_r[2] : lvl_a_r;
	wire b_lvl_nxt = b_agree ? sync_b_r[2] : lvl_b_r;
	wire a_rise = a_lvl_nxt & ~lvl_a_r;
	wire a_fall = ~a_lvl_nxt & lvl_a_r;
	wire b_rise = b_lvl_nxt & ~lvl_b_r;
	wire b_fall = ~b_lvl_nxt & lvl_b_r;

	function automatic logic sel_edge(input logic [1:0] sel, input logic rise, input logic fall);
		sel_edge = (sel[0] & rise) | (sel[1] & fall);
	endfunction

	function automatic logic apply_act(input logic cur, input tpr_action_t act);
		unique case (act)
			`TPR_ACT_NOP:    apply_act = cur;
			`TPR_ACT_SET:    apply_act = 1'b1;
			`TPR_ACT_RESET:  apply_act = 1'b0;
			`TPR_ACT_TOGGLE: apply_act = ~cur;
		endcase
	endfunction

	wire a_evt = sel_edge(edge_sel_a_in, a_rise, a_fall);
	wire b_evt = sel_edge(edge_sel_b_in, b_rise, b_fall);
	wire [3:0] m = input_mode_field_in;

	// Function decode per mode
	wire a_trig_mode = (m == `TPR_MODE_A_TRIG) | (m == `TPR_MODE_DUAL_TRIG) | (m == `TPR_MODE_TRIG_CLK) |
		(m == `TPR_MODE_TRIG_GATE);
	wire b_trig_mode = (m == `TPR_MODE_B_TRIG) | (m == `TPR_MODE_GATE_TRIG) | (m == `TPR_MODE_DUAL_TRIG) |
		(m == `TPR_MODE_CLK_TRIG);
	wire a_gate_mode = (m == `TPR_MODE_A_GATE) | (m == `TPR_MODE_GATE_TRIG) | (m == `TPR_MODE_GATE_CLK);
	wire b_gate_mode = (m == `TPR_MODE_TRIG_GATE);
	wire b_clk_mode = (m == `TPR_MODE_B_CLK) | (m == `TPR_MODE_GATE_CLK) | (m == `TPR_MODE_DIR_CLK) |
		(m == `TPR_MODE_TRIG_CLK);
	wire a_clk_mode = (m == `TPR_MODE_CLK_TRIG);
	wire step_mode = (m == `TPR_MODE_UP_DOWN) | (m == `TPR_MODE_AUTODISC);
	wire lvl_dir_mode = (m == `TPR_MODE_DIR_CLK) | (m == `TPR_MODE_DIR_ONLY);
	wire trig_dir_mode = (m == `TPR_MODE_TRIG_DIR);

	// Gate blocks counting while the gate pin is high
	wire gate_open = ~(a_gate_mode & lvl_a_r) & ~(b_gate_mode & lvl_b_r);

	// Prescaler clock source
	wire ext_tick = b_clk_mode ? b_evt : a_evt;
	wire presc_nxt = step_mode ? 1'b0 :
		(b_clk_mode | a_clk_mode) ? (ext_tick & gate_open) :
		(prescaler_tick_in & gate_open);

	// Step counting modes
	wire ud_up = (m == `TPR_MODE_UP_DOWN) & a_evt & ~b_evt;
	wire ud_dn = (m == `TPR_MODE_UP_DOWN) & b_evt;
	wire ad_up = (m == `TPR_MODE_AUTODISC) & b_rise & ~lvl_a_r;
	wire ad_dn = (m == `TPR_MODE_AUTODISC) & b_fall & ~lvl_a_r;

	// Triggers
	wire trig1_nxt = a_trig_mode & a_evt;
	wire trig2_nxt = b_trig_mode & b_evt & ~bivalue_mode_in;

	// Direction latched by trigger-up/down edges
	wire dir_lvl_nxt = (trig_dir_mode & b_evt) ? 1'b0 :
		(trig_dir_mode & a_evt) ? 1'b1 : dir_lvl_r;
	wire up_nxt = lvl_dir_mode ? lvl_a_r :
		trig_dir_mode ? dir_lvl_nxt :
		(m == `TPR_MODE_UP_DOWN) ? ~ud_dn :
		(m == `TPR_MODE_AUTODISC) ? ~ad_dn :
		sw_direction_bit_in;

	// Output actions, applied in order wrap, compare0, compare1
	logic out_a_r;
	logic out_b_r;
	wire a_s0 = wrap_event_in ? apply_act(out_a_r, out_a_wrap_act_in) : out_a_r;
	wire a_s1 = compare_first_event_in ? apply_act(a_s0, out_a_cmp0_act_in) : a_s0;
	wire a_s2 = compare_second_event_in ? apply_act(a_s1, out_a_cmp1_act_in) : a_s1;
	wire b_s0 = wrap_event_in ? apply_act(out_b_r, out_b_wrap_act_in) : out_b_r;
	wire b_s1 = compare_first_event_in ? apply_act(b_s0, out_b_cmp0_act_in) : b_s0;
	wire b_s2 = compare_second_event_in ? apply_act(b_s1, out_b_cmp1_act_in) : b_s1;
	wire out_a_nxt = preset_a_load_in ? preset_a_level_in : a_s2;
	wire out_b_nxt = preset_b_load_in ? preset_b_level_in : b_s2;
	wire event_nxt = (overflow_event_route_in & wrap_event_in) |
		(compare0_event_route_in & compare_first_event_in);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lvl_a_r <= 1'b0;
			lvl_b_r <= 1'b0;
			dir_lvl_r <= 1'b1;
			out_a_r <= 1'b0;
			out_b_r <= 1'b0;
		end else begin
			lvl_a_r <= a_lvl_nxt;
			lvl_b_r <= b_lvl_nxt;
			dir_lvl_r <= dir_lvl_nxt;
			out_a_r <= out_a_nxt;
			out_b_r <= out_b_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prescaler_clk_out <= 1'b0;
			count_up_out <= 1'b1;
			count_step_up_out <= 1'b0;
			count_step_down_out <= 1'b0;
			trigger_first_out <= 1'b0;
			trigger_second_out <= 1'b0;
			on_chip_event_out <= 1'b0;
		end else begin
			prescaler_clk_out <= presc_nxt;
			count_up_out <= up_nxt;
			count_step_up_out <= ud_up | ad_up;
			count_step_down_out <= ud_dn | ad_dn;
			trigger_first_out <= trig1_nxt;
			trigger_second_out <= trig2_nxt;
			on_chip_event_out <= event_nxt;
		end
	end

	assign direction_up_out = count_up_out;
	assign timer_output_a_out = out_a_r;
	assign timer_output_b_out = out_b_r;

	// Checks
	gate_blocks_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(a_gate_mode && lvl_a_r) |=> !prescaler_clk_out)
		else $error("gate A high let a tick through");

	bivalue_b_a : assert property (@(posedge clk_in) disable iff (srst_in)
		bivalue_mode_in |=> !trigger_second_out)
		else $error("B trigger in bivalue mode");

	ud_prio_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_UP_DOWN) && b_evt) |=> (count_step_down_out && !count_step_up_out))
		else $error("B did not win up/down");

	ad_up_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_AUTODISC) && b_rise && !lvl_a_r) |=> count_step_up_out)
		else $error("autodisc no increment");

	ad_high_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_AUTODISC) && lvl_a_r) |=> !(count_step_up_out || count_step_down_out))
		else $error("autodisc step with A high");

	sw_dir_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(m == `TPR_MODE_NONE) |=> (count_up_out == $past(sw_direction_bit_in)))
		else $error("software direction not followed");

	lvl_dir_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(m == `TPR_MODE_DIR_ONLY) |=> (count_up_out == $past(lvl_a_r)))
		else $error("level direction wrong");

	preset_out_a : assert property (@(posedge clk_in) disable iff (srst_in)
		preset_a_load_in |=> (timer_output_a_out == $past(preset_a_level_in)))
		else $error("preset A not applied");

	route_evt_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(overflow_event_route_in && wrap_event_in) |=> on_chip_event_out)
		else $error("wrap event not routed");

	trig1_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(a_trig_mode && a_evt) |=> trigger_first_out)
		else $error("A trigger lost");

	gate_b_blocks_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(b_gate_mode && lvl_b_r) |=> !prescaler_clk_out)
		else $error("gate B high let a tick through");

	int_tick_pass_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_NONE) && prescaler_tick_in) |=> prescaler_clk_out)
		else $error("internal tick lost");

	ext_clk_b_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_B_CLK) && b_evt) |=> prescaler_clk_out)
		else $error("B clock event lost");

	ext_clk_quiet_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_B_CLK) && !b_evt) |=> !prescaler_clk_out)
		else $error("internal tick leaked in B clock mode");

	gated_ext_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_GATE_CLK) && b_evt && !lvl_a_r) |=> prescaler_clk_out)
		else $error("open gate dropped B clock");

	dual_trig_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_DUAL_TRIG) && b_evt && !bivalue_mode_in) |=> trigger_second_out)
		else $error("dual mode B trigger lost");

	ud_up_step_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_UP_DOWN) && a_evt && !b_evt) |=> count_step_up_out)
		else $error("A step up lost");

	dir_clk_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(m == `TPR_MODE_DIR_CLK) |=> (count_up_out == $past(lvl_a_r)))
		else $error("level direction wrong with B clock");

	trig_dn_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_TRIG_DIR) && b_evt) |=> !count_up_out)
		else $error("B edge did not set down");

	trig_up_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_TRIG_DIR) && a_evt && !b_evt) |=> count_up_out)
		else $error("A edge did not set up");

	ad_dn_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_AUTODISC) && b_fall && !lvl_a_r) |=> count_step_down_out)
		else $error("autodisc no decrement");

	pin_dir_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(lvl_dir_mode && (sw_direction_bit_in != lvl_a_r)) |=> (count_up_out == $past(lvl_a_r)))
		else $error("software direction leaked into pin mode");

	trig_clk_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_TRIG_CLK) && b_evt) |=> prescaler_clk_out)
		else $error("B clock lost with A trigger");

	clk_trig_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_CLK_TRIG) && a_evt) |=> prescaler_clk_out)
		else $error("A clock event lost");

	cap_second_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_CLK_TRIG) && b_evt && !bivalue_mode_in) |=> trigger_second_out)
		else $error("B capture trigger lost");

	gate_trig_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_GATE_TRIG) && b_evt && !bivalue_mode_in) |=> trigger_second_out)
		else $error("B trigger lost with A gate");

	preset_out_b_a : assert property (@(posedge clk_in) disable iff (srst_in)
		preset_b_load_in |=> (timer_output_b_out == $past(preset_b_level_in)))
		else $error("preset B not applied");

	out_a_hold_a : assert property (@(posedge clk_in) disable iff (srst_in)
		!(wrap_event_in || compare_first_event_in || compare_second_event_in || preset_a_load_in) |=>
		(timer_output_a_out == $past(timer_output_a_out))) else $error("output A moved without event");

	out_b_hold_a : assert property (@(posedge clk_in) disable iff (srst_in)
		!(wrap_event_in || compare_first_event_in || compare_second_event_in || preset_b_load_in) |=>
		(timer_output_b_out == $past(timer_output_b_out))) else $error("output B moved without event");

	cmp1_set_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(compare_second_event_in && (out_a_cmp1_act_in == `TPR_ACT_SET) && !preset_a_load_in) |=> timer_output_a_out)
		else $error("compare-1 set lost");

	route_cmp0_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(compare0_event_route_in && compare_first_event_in) |=> on_chip_event_out)
		else $error("compare-0 event not routed");

	no_route_a : assert property (@(posedge clk_in) disable iff (srst_in)
		!((overflow_event_route_in && wrap_event_in) || (compare0_event_route_in && compare_first_event_in)) |=>
		!on_chip_event_out) else $error("spurious on-chip event");

	rise_only_a : assert property (@(posedge clk_in) disable iff (srst_in)
		((m == `TPR_MODE_A_TRIG) && (edge_sel_a_in == 2'h1) && a_fall) |=> !trigger_first_out)
		else $error("falling edge taken in rising mode");
endmodule

// *** tb/tpr_pin_source.sv ***
// Model of the external sources driving the two timer input pins
`timescale 1ns/1ps
module tpr_pin_source (
	input  wire logic clk_in,
	input  wire logic lvl_a_in,
	input  wire logic lvl_b_in,
	output logic      pin_a_out,
	output logic      pin_b_out
);
	initial {pin_a_out, pin_b_out} = 2'b00;
	// Pins move a few ns after the edge, unrelated to the sampling
	always @(posedge clk_in) begin
		pin_a_out <= #3 lvl_a_in;
		pin_b_out <= #3 lvl_b_in;
	end
endmodule

// *** tb/tpr_timer_pin_routing_test.sv ***
// Self-checking bench for the timer pin routing block
`timescale 1ns/1ps
`include "tpr_consts.svh"
module tpr_timer_pin_routing_test import tpr_pkg::*;;
	logic clk_in = 0, srst_in = 1, la = 0, lb = 0, pa, pb, swd = 1, biv = 0, tick = 0, c0 = 0, wr = 0;
	logic p = 0, ld = 0, rov = 0, rc0 = 0, c1 = 0, pr, up, su, sd, t1, t2, dir, oa, ob, compare0_event_route;
	tpr_mode_t mode = `TPR_MODE_NONE;
	logic [1:0] esa = 2'h1, esb = 2'h1;
	tpr_action_t act = `TPR_ACT_NOP;
	logic [3:0] n1, n2, nu, nd, np;
	int n_fail = 0, checked = 0, cyc = 0;
	always #10 clk_in = ~clk_in;
	tpr_pin_source src (.clk_in(clk_in), .lvl_a_in(la), .lvl_b_in(lb), .pin_a_out(pa), .pin_b_out(pb));
	tpr_timer_pin_routing uut (.clk_in(clk_in), .srst_in(srst_in), .ext_input_a_in(pa), .ext_input_b_in(pb),
		.input_mode_field_in(mode), .edge_sel_a_in(esa), .edge_sel_b_in(esb), .sw_direction_bit_in(swd),
		.bivalue_mode_in(biv), .prescaler_tick_in(tick), .compare_first_event_in(c0),
		.compare_second_event_in(c1), .wrap_event_in(wr), .out_a_cmp0_act_in(act), .out_a_cmp1_act_in(act),
		.out_a_wrap_act_in(2'h0), .out_b_cmp0_act_in(2'h0), .out_b_cmp1_act_in(act), .out_b_wrap_act_in(act),
		.preset_a_level_in(p), .preset_b_level_in(p), .preset_a_load_in(ld), .preset_b_load_in(ld),
		.overflow_event_route_in(rov), .compare0_event_route_in(rc0), .prescaler_clk_out(pr),
		.count_up_out(up), .count_step_up_out(su), .count_step_down_out(sd), .trigger_first_out(t1),
		.trigger_second_out(t2), .direction_up_out(dir), .timer_output_a_out(oa), .timer_output_b_out(ob),
		.on_chip_event_out(compare0_event_route));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: count %0d not %0d", $time, got, exp);
		end
	endtask
	task automatic chk_lvl(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: level %b not %b", $time, got, exp);
		end
	endtask
	// Sets mode and pin levels, then counts output pulses over eight cycles
	task automatic pins(input tpr_mode_t m, input logic a, input logic b);
		@(posedge clk_in);
		mode <= m;
		la <= a;
		lb <= b;
		{n1, n2, nu, nd, np} = '0;
		repeat (8) begin
			@(posedge clk_in);
			#1;
			n1 += t1;
			n2 += t2;
			nu += su;
			nd += sd;
			np += pr;
		end
	endtask
	task automatic t_trig;
		pins(`TPR_MODE_A_TRIG, 0, 0);
		pins(`TPR_MODE_A_TRIG, 1, 0);
		chk_cnt(n1, 1);
		pins(`TPR_MODE_A_TRIG, 0, 0);
		chk_cnt(n1, 0);
		@(posedge clk_in) esa <= 2'h3;
		pins(`TPR_MODE_A_TRIG, 1, 0);
		pins(`TPR_MODE_A_TRIG, 0, 0);
		chk_cnt(n1, 1);
		pins(`TPR_MODE_B_TRIG, 0, 1);
		chk_cnt(n2, 1);
		chk_cnt(n1, 0);
		@(posedge clk_in) biv <= 1;
		pins(`TPR_MODE_B_TRIG, 0, 0);
		pins(`TPR_MODE_B_TRIG, 0, 1);
		chk_cnt(n2, 0);
		$display("test triggers done");
	endtask
	task automatic t_gate;
		@(posedge clk_in) tick <= 1;
		pins(`TPR_MODE_A_GATE, 1, 0);
		pins(`TPR_MODE_A_GATE, 1, 0);
		chk_cnt(np, 0);
		pins(`TPR_MODE_A_GATE, 0, 0);
		pins(`TPR_MODE_A_GATE, 0, 0);
		chk_cnt(np, 8);
		pins(`TPR_MODE_NONE, 1, 0);
		chk_cnt(np, 8);
		chk_cnt(n1, 0);
		@(posedge clk_in) tick <= 0;
		$display("test gate done");
	endtask
	task automatic t_steps;
		@(posedge clk_in) esa <= 2'h1;
		pins(`TPR_MODE_UP_DOWN, 0, 0);
		pins(`TPR_MODE_UP_DOWN, 1, 0);
		chk_cnt(nu, 1);
		pins(`TPR_MODE_UP_DOWN, 0, 0);
		pins(`TPR_MODE_UP_DOWN, 1, 1);
		chk_cnt(nu, 0);
		chk_cnt(nd, 1);
		@(posedge clk_in) esb <= 2'h3;
		pins(`TPR_MODE_AUTODISC, 0, 0);
		pins(`TPR_MODE_AUTODISC, 0, 1);
		chk_cnt(nu, 1);
		pins(`TPR_MODE_AUTODISC, 0, 0);
		chk_cnt(nd, 1);
		pins(`TPR_MODE_AUTODISC, 1, 0);
		pins(`TPR_MODE_AUTODISC, 1, 1);
		chk_cnt(nu, 0);
		pins(`TPR_MODE_AUTODISC, 1, 0);
		chk_cnt(nd, 0);
		$display("test steps done");
	endtask
	// Direction sources and the combined clock, gate and trigger modes
	task automatic t_dir;
		@(posedge clk_in);
		biv <= 0;
		swd <= 0;
		pins(`TPR_MODE_NONE, 0, 0);
		chk_lvl(up, 0);
		pins(`TPR_MODE_DIR_ONLY, 1, 0);
		chk_lvl(up, 1);
		pins(`TPR_MODE_DIR_ONLY, 0, 0);
		chk_lvl(dir, 0);
		pins(`TPR_MODE_DIR_CLK, 1, 1);
		chk_lvl(up, 1);
		chk_cnt(np, 1);
		pins(`TPR_MODE_TRIG_DIR, 0, 0);
		chk_lvl(up, 0);
		pins(`TPR_MODE_TRIG_DIR, 1, 0);
		chk_lvl(up, 1);
		pins(`TPR_MODE_TRIG_DIR, 0, 1);
		pins(`TPR_MODE_TRIG_DIR, 1, 0);
		chk_lvl(up, 0);
		pins(`TPR_MODE_GATE_CLK, 1, 1);
		chk_cnt(np, 0);
		pins(`TPR_MODE_GATE_CLK, 0, 0);
		pins(`TPR_MODE_GATE_CLK, 0, 1);
		chk_cnt(np, 1);
		pins(`TPR_MODE_TRIG_CLK, 1, 0);
		chk_cnt(n1, 1);
		chk_cnt(np, 1);
		pins(`TPR_MODE_CLK_TRIG, 0, 1);
		chk_cnt(n2, 1);
		pins(`TPR_MODE_CLK_TRIG, 1, 1);
		chk_cnt(np, 1);
		@(posedge clk_in) tick <= 1;
		pins(`TPR_MODE_TRIG_GATE, 1, 1);
		chk_cnt(np, 0);
		pins(`TPR_MODE_TRIG_GATE, 0, 0);
		pins(`TPR_MODE_TRIG_GATE, 1, 0);
		chk_cnt(n1, 1);
		chk_cnt(np, 8);
		pins(`TPR_MODE_GATE_TRIG, 1, 1);
		chk_cnt(np, 0);
		chk_cnt(n2, 1);
		pins(`TPR_MODE_DUAL_TRIG, 0, 0);
		pins(`TPR_MODE_DUAL_TRIG, 1, 1);
		chk_cnt(n1, 1);
		chk_cnt(n2, 1);
		chk_cnt(np, 8);
		@(posedge clk_in) tick <= 0;
		$display("test modes done");
	endtask
	// Preset each output, then apply every action from compare-0 and wrap
	task automatic t_out;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			act <= i[1:0];
			p <= ~i[0];
			ld <= 1;
			@(posedge clk_in);
			ld <= 0;
			c0 <= 1;
			wr <= 1;
			#1;
			chk_lvl(oa, ~i[0]);
			@(posedge clk_in);
			c0 <= 0;
			wr <= 0;
			#1;
			chk_lvl(oa, 4'b1011 >> i);
			chk_lvl(ob, 4'b1011 >> i);
		end
		@(posedge clk_in);
		act <= `TPR_ACT_RESET;
		p <= 1;
		ld <= 1;
		@(posedge clk_in);
		ld <= 0;
		c1 <= 1;
		@(posedge clk_in);
		c1 <= 0;
		#1;
		chk_lvl(oa, 0);
		chk_lvl(ob, 0);
		$display("test outputs done");
	endtask
	task automatic ev(input logic ro, input logic rc, input logic w, input logic c, input logic e);
		@(posedge clk_in);
		rov <= ro;
		rc0 <= rc;
		wr <= w;
		c0 <= c;
		@(posedge clk_in);
		wr <= 0;
		c0 <= 0;
		#1;
		chk_lvl(compare0_event_route, e);
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		#1;
		chk_lvl(up, 1);
		chk_lvl(oa, 0);
		chk_lvl(t1, 0);
		@(posedge clk_in) srst_in <= 0;
		t_trig();
		t_gate();
		t_steps();
		t_dir();
		t_out();
		ev(1, 0, 1, 0, 1);
		ev(1, 0, 0, 1, 0);
		ev(0, 1, 0, 1, 1);
		ev(0, 1, 1, 0, 0);
		$display("test events done");
		end_of_test();
	end
endmodule
